// *** pkg/arp_pkg.sv ***
package arp_pkg;
  // frame layout and constant field values
  localparam logic [15:0] ETH_TYPE_ARP = 16'h0806;
  localparam logic [15:0] TPID_VLAN    = 16'h8100;
  localparam logic [15:0] ETH_LEN_MAX  = 16'h0600;
  localparam logic [15:0] ARP_HTYPE    = 16'h0001;
  localparam logic [15:0] ARP_PTYPE    = 16'h0800;
  localparam logic [7:0]  ARP_HLEN     = 8'h06;
  localparam logic [7:0]  ARP_PLEN     = 8'h04;
  localparam logic [15:0] ARP_OP_REQ   = 16'h0001;
  localparam logic [15:0] ARP_OP_REP   = 16'h0002;
  localparam logic [47:0] MAC_BCAST    = 48'hFFFF_FFFF_FFFF;
  // byte offsets from frame start, and the vlan tag and snap header lengths
  localparam logic [5:0]  OFF_SRC      = 6'h06;
  localparam logic [5:0]  OFF_TYPE     = 6'h0C;
  localparam logic [5:0]  LEN_VLAN     = 6'h04;
  localparam logic [5:0]  LEN_SNAP     = 6'h08;
  // byte offsets relative to the ethertype field
  localparam logic [5:0]  REL_HS       = 6'h06;
  localparam logic [5:0]  REL_OP       = 6'h08;
  localparam logic [5:0]  REL_SHA      = 6'h0A;
  localparam logic [5:0]  REL_SPA      = 6'h10;
  localparam logic [5:0]  REL_THA      = 6'h14;
  localparam logic [5:0]  REL_TPA      = 6'h1A;
  localparam logic [5:0]  REL_END      = 6'h1E;
  localparam logic [5:0]  COPY_BACK    = 6'h0A;
  localparam logic [6:0]  ARP_MIN      = 7'h2A;
  localparam logic [5:0]  FRM_DATA     = 6'h3C;
  localparam logic [5:0]  FRM_LAST     = 6'h3F;
  localparam logic [6:0]  BUF_BYTES    = 7'h40;
  localparam logic [6:0]  CNT_SAT      = 7'h7F;
  localparam int          IP_ENTRIES   = 3;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          FIFO_W       = 9;
  localparam int          PRX_ARP_BIT  = 5;
  localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB8_8320;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       crc_err;
    logic       csum_err;
    logic       wake;
  } arp_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } arp_tx_t;

  typedef enum logic [1:0] {
    ST_RX    = 2'b00,
    ST_CHK   = 2'b01,
    ST_GEN   = 2'b10,
    ST_DRAIN = 2'b11
  } arp_st_t;

  typedef struct packed {
    arp_st_t          st;
    logic [63:0][7:0] frm;
    logic [6:0]       rcnt;
    logic [6:0]       flen;
    logic             drop;
    logic             crc_err;
    logic             csum_err;
    logic             wake;
    logic [5:0]       idx;
    logic [31:0]      crc;
    logic             busy;
    logic             dropped;
  } arp_core_st_t;

  // reflected ethernet crc, one byte
  function automatic logic [31:0] arp_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// *** rtl/arp_proxy_responder.sv ***
module arp_fifo import arp_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic              o_empty
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic [W-1:0]        dout;
    logic                ov;
  } arp_fifo_st_t;
  arp_fifo_st_t s_r;
  arp_fifo_st_t s_nxt;
  logic push;
  logic load;

  // output register in front of the array keeps the read side flop-driven
  assign o_ready = s_r.cnt != (AW+1)'(D);
  assign push    = i_valid && o_ready;
  assign load    = (s_r.cnt != '0) && (!s_r.ov || i_ready);
  assign o_data  = s_r.dout;
  assign o_valid = s_r.ov;
  assign o_empty = (s_r.cnt == '0) && !s_r.ov;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = i_data;
      s_nxt.wp = s_r.wp + 1'b1; // depth must be a power of two
    end
    if (load) begin
      s_nxt.dout = s_r.mem[s_r.rp];
      s_nxt.ov = 1'b1;
      s_nxt.rp = s_r.rp + 1'b1;
    end else if (i_ready) begin
      s_nxt.ov = 1'b0;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // arp_fifo

module arp_proxy_responder import arp_pkg::*; (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_b,
  input  wire logic [15:0]                   i_proxy_control,
  input  wire logic [47:0]                   i_station_mac,
  input  wire logic [IP_ENTRIES-1:0][31:0]   i_ipv4_address_table,
  input  wire logic [IP_ENTRIES-1:0]         i_ipv4_valid,
  input  wire arp_rx_t                       i_rx,
  input  wire logic                          i_rx_valid,
  output arp_tx_t                            o_tx,
  output logic                               o_tx_valid,
  input  wire logic                          i_tx_ready,
  output logic                               o_busy,
  output logic                               o_drop
);
  arp_core_st_t s;
  arp_core_st_t n;
  logic         vlan;
  logic [5:0]   soff;
  logic [5:0]   base;
  logic [5:0]   rel;
  logic [47:0]  f_dst;
  logic [47:0]  f_typ;
  logic [47:0]  f_hs;
  logic [47:0]  f_tpa;
  logic [31:0]  tip;
  logic [31:0]  sub_ip;
  logic [31:0]  sip;
  logic [31:0]  crc_inv;
  logic         sub_ok;
  logic         ip_hit;
  logic         ip_zero;
  logic         ip_ok;
  logic         dst_ok;
  logic         type_ok;
  logic         hdr_ok;
  logic         len_ok;
  logic         match;
  logic         push;
  logic         fifo_rdy;
  logic         fifo_empty;
  logic [7:0]   rbyte;
  arp_tx_t      tx_in;

  // six bytes starting at a variable offset, first byte on top
  function automatic logic [47:0] fld(input logic [63:0][7:0] b, input logic [5:0] i);
    return {b[i], b[i+6'h01], b[i+6'h02], b[i+6'h03], b[i+6'h04], b[i+6'h05]};
  endfunction

  function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [5:0] k);
    return m[8*(5-int'(k)) +: 8];
  endfunction

  // locate the ethertype behind optional tag and snap header
  assign vlan  = {s.frm[OFF_TYPE], s.frm[OFF_TYPE+6'h01]} == TPID_VLAN;
  assign soff  = OFF_TYPE + (vlan ? LEN_VLAN : 6'h00);
  assign base  = soff + (({s.frm[soff], s.frm[soff+6'h01]} < ETH_LEN_MAX) ? LEN_SNAP : '0);
  assign f_dst = fld(s.frm, 6'h00);
  assign f_typ = fld(s.frm, base);
  assign f_hs  = fld(s.frm, base + REL_HS);
  assign f_tpa = fld(s.frm, base + REL_TPA);
  assign tip   = f_tpa[47:16];

  // field checks; sender fields and target mac are never looked at
  assign dst_ok  = (f_dst == MAC_BCAST) || (f_dst == i_station_mac);
  assign type_ok = f_typ[47:32] == ETH_TYPE_ARP;
  assign hdr_ok  = (f_typ[31:0] == {ARP_HTYPE, ARP_PTYPE}) &&
                   (f_hs[47:16] == {ARP_HLEN, ARP_PLEN, ARP_OP_REQ});
  assign len_ok  = ({1'b0, base} + ARP_MIN) <= s.flen; // short frames would read stale bytes
  assign ip_zero = tip == 32'h0000_0000;
  assign ip_ok   = ip_hit || (ip_zero && sub_ok);
  assign sip     = ip_zero ? sub_ip : tip;
  assign match   = i_proxy_control[PRX_ARP_BIT] && dst_ok && type_ok && hdr_ok && ip_ok &&
                   len_ok && !s.crc_err && !s.csum_err && !s.wake;

  // table lookup; lowest valid entry stands in for a zero target
  always_comb begin
    ip_hit = 1'b0;
    sub_ok = 1'b0;
    sub_ip = 32'h0000_0000;
    for (int k = IP_ENTRIES - 1; k >= 0; k--) begin
      if (i_ipv4_valid[k]) begin
        sub_ip = i_ipv4_address_table[k];
        sub_ok = 1'b1;
        if (i_ipv4_address_table[k] == tip) begin
          ip_hit = 1'b1;
        end
      end
    end
  end

  // reply byte at s.idx, built from the held request
  always_comb begin
    rel     = s.idx - base;
    crc_inv = ~s.crc;
    rbyte   = 8'h00;
    if (s.idx >= FRM_DATA) begin
      rbyte = crc_inv[{s.idx[1:0], 3'b000} +: 8];
    end else if (s.idx < OFF_SRC) begin
      rbyte = s.frm[s.idx + OFF_SRC];
    end else if (s.idx < OFF_TYPE) begin
      rbyte = mac_byte(i_station_mac, s.idx - OFF_SRC);
    end else if (s.idx < base + REL_OP) begin
      rbyte = s.frm[s.idx];
    end else if (rel < REL_SHA) begin
      rbyte = rel[0] ? ARP_OP_REP[7:0] : ARP_OP_REP[15:8];
    end else if (rel < REL_SPA) begin
      rbyte = mac_byte(i_station_mac, rel - REL_SHA);
    end else if (rel < REL_THA) begin
      rbyte = sip[{~rel[1:0], 3'b000} +: 8];
    end else if (rel < REL_END) begin
      rbyte = s.frm[s.idx - COPY_BACK];
    end
  end

  assign tx_in.data = rbyte;
  assign tx_in.last = s.idx == FRM_LAST;

  // receive capture, match, reply generation
  always_comb begin
    n = s;
    n.dropped = 1'b0;
    push = 1'b0;
    if (i_rx_valid) begin
      if (s.rcnt == 7'h00) begin
        n.drop = s.st != ST_RX;
        n.dropped = n.drop;
      end
      if (!n.drop && s.rcnt < BUF_BYTES) begin
        n.frm[s.rcnt[5:0]] = i_rx.data;
      end
      if (s.rcnt != CNT_SAT) begin
        n.rcnt = s.rcnt + 7'h01;
      end
      if (i_rx.last) begin
        n.flen     = n.rcnt;
        n.rcnt     = 7'h00;
        n.crc_err  = i_rx.crc_err;
        n.csum_err = i_rx.csum_err;
        n.wake     = i_rx.wake;
        if (!n.drop) begin
          n.st = ST_CHK;
        end
      end
    end
    unique case (s.st)
      ST_RX: begin
      end
      ST_CHK: begin
        if (match) begin
          n.st  = ST_GEN;
          n.idx = 6'h00;
          n.crc = CRC_INIT;
        end else begin
          n.st = ST_RX;
        end
      end
      ST_GEN: begin
        push = 1'b1;
        if (fifo_rdy) begin
          if (s.idx < FRM_DATA) begin
            n.crc = arp_crc8(s.crc, rbyte);
          end
          n.idx = s.idx + 6'h01;
          if (s.idx == FRM_LAST) begin
            n.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (fifo_empty) begin
          n.st = ST_RX;
        end
      end
    endcase
    n.busy = n.st != ST_RX;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_busy = s.busy;
  assign o_drop = s.dropped;

  // generator stalls on a full fifo, so a slow transmit path backs up cleanly
  arp_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_data  (tx_in),
    .i_valid (push),
    .o_ready (fifo_rdy),
    .o_data  (o_tx),
    .o_valid (o_tx_valid),
    .i_ready (i_tx_ready),
    .o_empty (fifo_empty)
  );

  // checks on the match and build path
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_chk_go;
    s.st == ST_CHK ##1 s.st == ST_GEN;
  endsequence

  property p_off;
    (s.st == ST_CHK && !i_proxy_control[PRX_ARP_BIT]) |=> s.st == ST_RX;
  endproperty
  a_off: assert property (p_off) else $error("reply started while proxy off");

  property p_ip;
    s_chk_go |-> $past(ip_ok);
  endproperty
  a_ip: assert property (p_ip) else $error("reply for unknown target ip");

  property p_dst;
    s_chk_go |-> $past(dst_ok);
  endproperty
  a_dst: assert property (p_dst) else $error("reply for foreign destination mac");

  property p_type;
    s_chk_go |-> $past(type_ok && hdr_ok);
  endproperty
  a_type: assert property (p_type) else $error("reply for non-arp-request frame");

  property p_err;
    s_chk_go |-> !$past(s.crc_err || s.csum_err);
  endproperty
  a_err: assert property (p_err) else $error("reply for errored frame");

  property p_wake;
    (s.st == ST_CHK && s.wake) |=> s.st == ST_RX;
  endproperty
  a_wake: assert property (p_wake) else $error("reply for wake frame");

  property p_sip;
    (push && s.idx == base + REL_SPA) |-> tx_in.data == sip[31:24];
  endproperty
  a_sip: assert property (p_sip) else $error("wrong sender ip byte");

  property p_end;
    (push && fifo_rdy && tx_in.last) |=> s.st == ST_DRAIN && s.idx == 6'h00;
  endproperty
  a_end: assert property (p_end) else $error("reply not 64 bytes");

  property p_one;
    (i_rx_valid && s.rcnt == 7'h00 && s.st inside {ST_GEN, ST_DRAIN}) |=> s.drop && o_drop;
  endproperty
  a_one: assert property (p_one) else $error("request not dropped while busy");
endmodule // arp_proxy_responder

// *** dv/arp_node_model.sv ***
// remote node: sends requests on rx, sinks replies on tx at a chosen pace
module arp_node_model import arp_pkg::*; (
  input  wire logic    i_mclk,
  input  wire logic    i_slow,
  input  wire logic    i_stall,
  input  wire arp_tx_t i_tx,
  input  wire logic    i_tx_valid,
  output arp_rx_t      o_rx,
  output logic         o_rx_valid,
  output logic         o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got[$];
  logic [1:0] pace;

  initial begin
    o_rx = '0;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
    pace = 2'h0;
  end

  // slow takes one byte in four; stall shuts the path so the fifo backs up
  always @(posedge i_mclk) begin
    pace <= pace + 2'h1;
    o_tx_ready <= !i_stall && (!i_slow || pace == 2'h0);
    if (i_tx_valid && o_tx_ready) got.push_back({i_tx.data, i_tx.last});
  end

  // one byte per cycle, flags driven on every beat
  task automatic send(input logic [7:0] f[80], input int n, input logic [2:0] fl);
    for (int i = 0; i < n; i++) begin
      @(negedge i_mclk);
      o_rx_valid = 1'b1;
      o_rx = '{f[i], i == n - 1, fl[2], fl[1], fl[0]};
    end
    @(negedge i_mclk);
    o_rx_valid = 1'b0;
    // idle line shows no stale byte
    o_rx = '{~o_rx.data, 1'b0, 1'b0, 1'b0, 1'b0};
  endtask
endmodule // arp_node_model

// *** dv/testbench.sv ***
module testbench import arp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       vlan, snap, en;
    logic [1:0] dst;  // bcast, station, other
    logic [2:0] tip;  // entry 0..2, zero, unknown
    logic [1:0] bad;  // none, type, opcode, hw type
    logic [2:0] fl;   // crc, csum, wake
    logic [2:0] val;
    logic       exp;
  } arp_case_t;
  arp_case_t rows[15] = '{'{0,0,1,0,0,0,0,7,1}, '{1,0,1,1,2,0,0,7,1}, '{0,1,1,0,1,0,0,7,1},
    '{1,1,1,1,3,0,0,6,1}, '{0,0,0,0,0,0,0,7,0}, '{0,0,1,2,0,0,0,7,0}, '{0,0,1,0,4,0,0,7,0},
    '{0,0,1,0,0,0,0,6,0}, '{1,0,1,0,0,1,0,7,0}, '{0,1,1,0,0,2,0,7,0}, '{0,0,1,0,0,3,0,7,0},
    '{0,0,1,0,0,0,4,7,0}, '{0,0,1,0,0,0,2,7,0}, '{0,0,1,0,0,0,1,7,0}, '{0,0,1,0,3,0,0,0,0}};
  logic                        mclk = 1'b0;
  logic                        rst_b = 1'b0;
  logic [15:0]                 prx = 16'h0000;
  logic [47:0]                 smac = 48'h0200_0000_5a5a;
  logic [IP_ENTRIES-1:0][31:0] ipt = {32'h0a00_0003, 32'h0a00_0002, 32'h0a00_0001};
  logic [IP_ENTRIES-1:0]       ipv = 3'h7;
  logic                        slow = 1'b0;
  logic                        stall = 1'b0;
  arp_rx_t                     rx;
  logic                        rx_valid, tx_valid, tx_ready, busy, drop;
  arp_tx_t                     tx;
  logic [7:0]                  req[80];
  logic [7:0]                  rep[80];
  int                          rlen, fail_count, num_checks, cycles, drops;

  always #4 mclk = ~mclk;

  arp_proxy_responder u_arp_proxy_responder (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_proxy_control(prx), .i_station_mac(smac), .i_ipv4_address_table(ipt),
    .i_ipv4_valid(ipv), .i_rx(rx), .i_rx_valid(rx_valid), .o_tx(tx), .o_tx_valid(tx_valid),
    .i_tx_ready(tx_ready), .o_busy(busy), .o_drop(drop));
  arp_node_model u_arp_node_model (.i_mclk(mclk), .i_slow(slow), .i_stall(stall), .i_tx(tx),
    .i_tx_valid(tx_valid), .o_rx(rx), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));

  // cycle ceiling well above the longest expected run
  always @(posedge mclk) begin
    cycles++;
    if (drop === 1'b1) drops++;
    if (cycles == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic put(input bit to_rep, input int at, input logic [47:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      if (to_rep) rep[at + k] = v[8 * (n - 1 - k) +: 8];
      else req[at + k] = v[8 * (n - 1 - k) +: 8];
    end
  endtask

  // request frame and the reply it should draw, crc worked out here
  task automatic build(input arp_case_t c);
    int b;
    logic [31:0] tip, sip, e, crc;
    logic [47:0] src;
    src = 48'h0200_0000_0a01;
    sip = 32'hc0a8_0017;
    tip = c.tip < 3 ? ipt[c.tip[1:0]] : (c.tip == 3 ? 32'h0000_0000 : 32'h0a00_0063);
    for (int i = 0; i < 80; i++) req[i] = 8'h00;
    put(0, 0, c.dst == 0 ? MAC_BCAST : (c.dst == 1 ? smac : 48'h0200_0000_0bbb), 6);
    put(0, 6, src, 6);
    b = 12;
    if (c.vlan) put(0, b, 32'h8100_0005, 4);
    b += c.vlan ? 4 : 0;
    if (c.snap) put(0, b, 48'h0032_aaaa_0300, 6);
    if (c.snap) put(0, b + 6, 16'h0000, 2);
    b += c.snap ? 8 : 0;
    put(0, b, c.bad == 1 ? 16'h0800 : ETH_TYPE_ARP, 2);
    put(0, b + 2, c.bad == 3 ? 16'h0006 : ARP_HTYPE, 2);
    put(0, b + 4, {ARP_PTYPE, ARP_HLEN, ARP_PLEN}, 4);
    put(0, b + 8, c.bad == 2 ? ARP_OP_REP : ARP_OP_REQ, 2);
    // sender mac differs from the frame source so a swapped copy shows
    put(0, b + 10, src ^ 48'h0000_0000_00f0, 6);
    put(0, b + 16, sip, 4);
    put(0, b + 20, 48'h1111_2222_3333, 6);
    put(0, b + 26, tip, 4);
    rlen = 52 + b;
    for (int i = 0; i < 80; i++) rep[i] = (i >= 12 && i < b + 8) ? req[i] : 8'h00;
    e = tip;
    for (int k = 2; k >= 0; k--) if (c.tip == 3 && c.val[k]) e = ipt[k];
    put(1, 0, src, 6);
    put(1, 6, smac, 6);
    put(1, b + 8, ARP_OP_REP, 2);
    put(1, b + 10, smac, 6);
    put(1, b + 16, e, 4);
    put(1, b + 20, src ^ 48'h0000_0000_00f0, 6);
    put(1, b + 26, sip, 4);
    crc = CRC_INIT;
    for (int i = 0; i < 60; i++) begin
      crc ^= {24'h00_0000, rep[i]};
      for (int k = 0; k < 8; k++) crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    end
    crc = ~crc;
    put(1, 60, {crc[7:0], crc[15:8], crc[23:16], crc[31:24]}, 4);
  endtask

  // wait for a whole reply, or for silence, then compare byte by byte
  task automatic expect_reply(input logic exp);
    logic [8:0] g[$];
    for (int w = 0; w < 600 && u_arp_node_model.got.size() < 64; w++) @(posedge mclk);
    // finish on a falling edge so whatever the caller drives next lands there
    repeat (60) @(negedge mclk);
    g = u_arp_node_model.got;
    check(32'(g.size()), exp ? 32'd64 : 32'd0);
    for (int i = 0; i < 64 && exp; i++) begin
      check(32'(g[i]), 32'({rep[i], 1'(i == 63)}));
    end
    check({31'h0, busy}, 32'h0);
    u_arp_node_model.got.delete();
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    check({29'h0, tx_valid, busy, drop}, 32'h0);
    rst_b = 1'b1;
    // valid bits and pace first, enable last
    foreach (rows[r]) begin
      @(negedge mclk);
      ipv = rows[r].val;
      slow = r[0];
      prx = rows[r].en ? 16'h0020 : 16'h0000;
      build(rows[r]);
      u_arp_node_model.send(req, rlen, rows[r].fl);
      expect_reply(rows[r].exp);
    end
    // a second request while a reply is held back is dropped whole
    ipv = 3'h7;
    prx = 16'h0020;
    stall = 1'b1;
    build(rows[1]);
    u_arp_node_model.send(req, rlen, 3'h0);
    repeat (40) @(negedge mclk);
    // nothing so far arrived while busy, so nothing may have been dropped
    check(32'(drops), 32'd0);
    drops = 0;
    check({31'h0, busy}, 32'h1);
    u_arp_node_model.send(req, rlen, 3'h0);
    repeat (4) @(negedge mclk);
    check(32'(drops), 32'd1);
    stall = 1'b0;
    expect_reply(1'b1);
    // reset in mid-reply clears everything, then a fresh request is served
    stall = 1'b1;
    u_arp_node_model.send(req, rlen, 3'h0);
    repeat (30) @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    check({29'h0, tx_valid, busy, drop}, 32'h0);
    rst_b = 1'b1;
    stall = 1'b0;
    u_arp_node_model.got.delete();
    u_arp_node_model.send(req, rlen, 3'h0);
    expect_reply(1'b1);
    stop_test();
  end
endmodule // testbench
